// ### rtl/watchdog_timer.sv
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - An awake timeout without a clear instruction in the period raises a system reset.
// - The count advances only on ticks of the 31 kHz oscillator, 32 ticks per 1 ms.
// - Mode 11 keeps the watchdog active always, also in Sleep, ignoring the enable bit.
// - Mode 10 keeps the watchdog active while awake and disabled in Sleep.
// - Mode 01 runs the watchdog when the enable bit is 1 and stops it when 0.
// - A disabled watchdog holds its count at zero.
// - The period field sets the limit to 32 times two to its value, reserved codes give 32.
// - After reset the period field holds 01011, a two second timeout.
// - Reset, the clear instruction, oscillator failure and a running start-up timer clear the count.
// - Sleep entry and Sleep exit each clear the count, which keeps running in Sleep if enabled.
// - Leaving Sleep on a crystal clock holds the count clear until the start-up timer ends.
// - A timeout in Sleep wakes the device instead of resetting it and updates the flags.
// - The oscillator divider selection has no effect on the count.
// - Control bits 7-6 read zero, bits 5-1 hold the period, bit 0 is the enable resetting to 0.
// - In software mode the enable bit keeps its value across Sleep.
// - Sleep entry sets the timeout flag and clears the power-down flag, both active low.
module watchdog_timer
    import watchdog_pkg::*;
#(
    parameter int CNT_W = WDT_CNT_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic low_freq_osc,
    input wire logic [1:0] wdt_mode_config,
    input wire logic in_sleep,
    input wire logic crystal_clock,
    input wire logic watchdog_clear_instr,
    input wire logic osc_fail,
    input wire logic osc_startup_timer,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic wdt_reset_req,
    output logic wake_req,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic wdog_reset_flag_n,
    output logic irq
);

    // reserved codes clamp.
    // Prescale limit; reserved codes fall back to the shortest interval.
    function automatic logic [CNT_W-1:0] period_limit(input logic [4:0] ps);
        logic [CNT_W-1:0] lim;
        lim = BASE_TICKS;
        if (ps <= PS_MAX_CODE) begin
            lim = BASE_TICKS << ps;
        end
        return lim;
    endfunction

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic [CNT_W-1:0] count_q, count_d;
    logic [4:0] period_sel_q;
    logic soft_enable_q;
    logic lf_q, sleep_q, ost_q, hold_q;
    logic reset_req_q, wake_req_q;
    logic to_n_q, pd_n_q, wdog_reset_flag_n_n_q;
    logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
    logic [7:0] rd_data_q;

    wire wdt_mode_t mode_w = wdt_mode_t'(wdt_mode_config);
    wire logic wr_ctrl = wr_en && addr_hit(addr, ADDR_CONTROL);
    wire logic wr_flags = wr_en && addr_hit(addr, ADDR_FLAGS);
    wire logic wr_istat = wr_en && addr_hit(addr, ADDR_IRQ_STATUS);
    wire logic wr_imask = wr_en && addr_hit(addr, ADDR_IRQ_MASK);
    wire logic lf_tick = low_freq_osc && !lf_q;
    wire logic sleep_entry = in_sleep && !sleep_q;
    wire logic sleep_exit = !in_sleep && sleep_q;
    wire logic [CNT_W-1:0] limit_w = period_limit(period_sel_q);
    wire logic [CNT_W-1:0] count_inc = count_q + {{(CNT_W-1){1'b0}}, 1'b1};

    logic active;
    always_comb begin
        unique case (mode_w)
            MODE_ON: active = 1'b1;
            MODE_AWAKE: active = !in_sleep;
            MODE_SOFT: active = soft_enable_q;
            MODE_OFF: active = 1'b0;
        endcase
    end

    wire logic clear_cond = !active || watchdog_clear_instr || osc_fail || osc_startup_timer
        || sleep_entry || sleep_exit || hold_q;
    wire logic hit = active && lf_tick && !clear_cond && (count_inc >= limit_w);
    wire logic awake_to = hit && !in_sleep;
    wire logic sleep_to = hit && in_sleep;

    // only oscillator ticks advance the count.
    always_comb begin
        count_d = count_q;
        if (clear_cond || hit) begin
            count_d = '0;
        end else if (lf_tick) begin
            count_d = count_inc;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (ce) begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lf_q <= 1'b0;
            sleep_q <= 1'b0;
            ost_q <= 1'b0;
        end else if (ce) begin
            lf_q <= low_freq_osc;
            sleep_q <= in_sleep;
            ost_q <= osc_startup_timer;
        end
    end

    // hold after a crystal wake until the start-up timer falls.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
        end else if (ce) begin
            if (sleep_exit && crystal_clock) begin
                hold_q <= 1'b1;
            end else if (ost_q && !osc_startup_timer) begin
                hold_q <= 1'b0;
            end
        end
    end

    // enable changes only on a write, never on Sleep.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            period_sel_q <= PS_RESET;
            soft_enable_q <= EN_RESET;
        end else if (ce && wr_ctrl) begin
            period_sel_q <= wr_data[CTRL_PS_MSB:CTRL_PS_LSB];
            soft_enable_q <= wr_data[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reset_req_q <= 1'b0;
            wake_req_q <= 1'b0;
        end else if (ce) begin
            reset_req_q <= awake_to;
            wake_req_q <= sleep_to;
        end
    end

    // sleep timeout flags; the hardware clear beats a software restore.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
            wdog_reset_flag_n_n_q <= 1'b1;
        end else if (ce) begin
            if (sleep_to) begin
                to_n_q <= 1'b0;
                pd_n_q <= 1'b0;
            end else if (sleep_entry) begin
                to_n_q <= 1'b1;
                pd_n_q <= 1'b0;
            end else if (watchdog_clear_instr) begin
                to_n_q <= 1'b1;
                pd_n_q <= 1'b1;
            end
            if (hit) begin
                wdog_reset_flag_n_n_q <= 1'b0;
            end else if (wr_flags && wr_data[FLG_WDOG_RESET_FLAG_N_BIT]) begin
                wdog_reset_flag_n_n_q <= 1'b1;
            end
        end
    end

    // Events set the sticky bits; a set in the same cycle as a clear wins.
    assign irq_set[IRQ_AWAKE_BIT] = awake_to;
    assign irq_set[IRQ_SLEEP_BIT] = sleep_to;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_mask_q <= IRQ_MASK_RESET;
        end else if (ce) begin
            irq_stat_q <= irq_set | (irq_stat_q & ~(wr_istat ? wr_data[IRQ_W-1:0] : '0));
            if (wr_imask) begin
                irq_mask_q <= wr_data[IRQ_W-1:0];
            end
        end
    end

    // control read layout with zero top bits.
    wire logic [7:0] ctrl_rd = {2'b00, period_sel_q, soft_enable_q};
    wire logic [7:0] flags_rd = {3'b000, in_sleep, active, wdog_reset_flag_n_n_q, pd_n_q, to_n_q};
    wire logic [7:0] rd_mux = addr_hit(addr, ADDR_CONTROL) ? ctrl_rd
        : addr_hit(addr, ADDR_FLAGS) ? flags_rd
        : addr_hit(addr, ADDR_IRQ_STATUS) ? {6'b00_0000, irq_stat_q}
        : addr_hit(addr, ADDR_IRQ_MASK) ? {6'b00_0000, irq_mask_q}
        : 8'h00;

    // Read data stand one cycle only, so a stale value never looks valid.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else if (ce) begin
            rd_data_q <= rd_en ? rd_mux : 8'h00;
        end
    end

    assign rd_data = rd_data_q;
    assign wdt_reset_req = reset_req_q;
    assign wake_req = wake_req_q;
    assign timeout_flag_n = to_n_q;
    assign powerdown_flag_n = pd_n_q;
    assign wdog_reset_flag_n = wdog_reset_flag_n_n_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    AST_AWAKE_RESET: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && active && lf_tick && !clear_cond && !in_sleep && count_inc >= limit_w)
        |=> (wdt_reset_req && !wdog_reset_flag_n && count_q == '0))
        else $error("Awake timeout gave no reset request.");

    AST_ALWAYS_ON: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_w == MODE_ON && in_sleep && sleep_q && lf_tick && !clear_cond && !hit)
        |=> count_q == $past(count_q) + 1)
        else $error("Always-on watchdog did not count in Sleep.");

    AST_SLEEP_OFF: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_w == MODE_AWAKE && in_sleep) |=> count_q == '0)
        else $error("Watchdog counted in Sleep in mode 10.");

    AST_SOFT_OFF: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_w == MODE_SOFT && !soft_enable_q) |=> count_q == '0)
        else $error("Software-disabled watchdog counted.");

    AST_MODE_OFF: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_w == MODE_OFF) [*2] |-> count_q == '0)
        else $error("Disabled watchdog count not zero.");

    AST_RESERVED_PERIOD: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (period_sel_q > PS_MAX_CODE) |-> limit_w == BASE_TICKS)
        else $error("Reserved period code not minimum interval.");

    AST_PERIOD_RESET: assert property (
        @(posedge ref_clk)
        !rst_n |=> (period_sel_q == PS_RESET && limit_w == 24'h01_0000))
        else $error("Period select reset value wrong.");

    AST_CLEAR_INSTR: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && (watchdog_clear_instr || osc_fail || osc_startup_timer)) |=> count_q == '0)
        else $error("Clear source did not clear the count.");

    AST_SLEEP_ENTRY: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && sleep_entry && !hit) |=> (count_q == '0 && timeout_flag_n && !powerdown_flag_n))
        else $error("Sleep entry did not clear count and set flags.");

    AST_CRYSTAL_HOLD: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && sleep_exit && crystal_clock) ##1 (ce && hold_q) |=> count_q == '0)
        else $error("Count moved during start-up hold.");

    AST_SLEEP_WAKE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && sleep_to)
        |=> (wake_req && !wdt_reset_req && !timeout_flag_n && !wdog_reset_flag_n))
        else $error("Sleep timeout did not wake cleanly.");

    AST_CTRL_READ: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && rd_en && addr == ADDR_CONTROL && !wr_en)
        |=> (rd_data[7:6] == 2'b00 && rd_data[5:1] == $past(period_sel_q)))
        else $error("Control register read layout wrong.");

    AST_ENABLE_KEPT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !wr_ctrl |=> $stable(soft_enable_q))
        else $error("Enable bit changed without a write.");

    AST_SINGLE_PULSE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wdt_reset_req |=> !wdt_reset_req)
        else $error("Reset request longer than one cycle.");

    AST_WAKE_PULSE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wake_req |=> !wake_req)
        else $error("Wake request longer than one cycle.");

    AST_HOLD_RELEASE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && ost_q && !osc_startup_timer && !(sleep_exit && crystal_clock)) |=> !hold_q)
        else $error("Start-up hold not released when the timer ended.");

    AST_FLAG_RESTORE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && wr_flags && wr_data[FLG_WDOG_RESET_FLAG_N_BIT] && !hit) |=> wdog_reset_flag_n)
        else $error("Watchdog reset flag not restored by a write.");

    AST_PERIOD_WRITE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && wr_ctrl) |=> period_sel_q == $past(wr_data[CTRL_PS_MSB:CTRL_PS_LSB]))
        else $error("Period select did not take the written value.");

    AST_STATUS_STICKY: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && !wr_istat) |=> ((irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q)))
        else $error("Interrupt status bit lost without a clear.");

    COV_AWAKE_TIMEOUT: cover property (@(posedge ref_clk) disable iff (!rst_n) awake_to && ce);
    COV_SLEEP_WAKE: cover property (@(posedge ref_clk) disable iff (!rst_n) sleep_to && ce);
    COV_CRYSTAL_HOLD: cover property (@(posedge ref_clk) disable iff (!rst_n) hold_q ##1 !hold_q);
    COV_IRQ: cover property (@(posedge ref_clk) disable iff (!rst_n) irq);

endmodule

// ### rtl/watchdog_pkg.sv
package watchdog_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h01;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h02;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h03;

    // Control register layout.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PS_LSB = 1;
    localparam int CTRL_PS_MSB = 5;

    // Flags register layout.
    localparam int FLG_TO_BIT = 0;
    localparam int FLG_PD_BIT = 1;
    localparam int FLG_WDOG_RESET_FLAG_N_BIT = 2;
    localparam int FLG_ACTIVE_BIT = 3;
    localparam int FLG_SLEEP_BIT = 4;

    // Interrupt event layout.
    localparam int IRQ_W = 2;
    localparam int IRQ_AWAKE_BIT = 0;
    localparam int IRQ_SLEEP_BIT = 1;

    // Reset values.
    localparam logic [4:0] PS_RESET = 5'h0b;
    localparam logic EN_RESET = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

    // Time base: one nominal 1 ms interval is 32 ticks of the 31 kHz oscillator.
    localparam int LF_OSC_KHZ = 31;
    localparam int BASE_INTERVAL_MS = 1;
    localparam int WDT_CNT_W = 24;
    localparam logic [WDT_CNT_W-1:0] BASE_TICKS = 24'h00_0020;
    localparam logic [4:0] PS_MAX_CODE = 5'h12;

    // Operating modes of the configuration field.
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_SOFT = 2'b01,
        MODE_AWAKE = 2'b10,
        MODE_ON = 2'b11
    } wdt_mode_t;

endpackage

// ### verif/watchdog_timer_tb.sv
`timescale 1ns/10ps
module watchdog_timer_tb;
    import watchdog_pkg::*;
    logic ref_clk, rst_n, ce, low_freq_osc, in_sleep, crystal_clock;
    logic watchdog_clear_instr, osc_fail, osc_startup_timer, wr_en, rd_en;
    logic [1:0] wdt_mode_config;
    logic [7:0] addr, wr_data, rd_data, rdv;
    logic wdt_reset_req, wake_req, timeout_flag_n, powerdown_flag_n, wdog_reset_flag_n, irq;
    logic [31:0] seed;
    logic [4:0] codes [4];
    int num_errors = 0;
    int cmp_count = 0;
    int rst_seen = 0;
    int wake_seen = 0;
    int rst_exp = 0;
    int wake_exp = 0;
    bit a;

    watchdog_timer i_watchdog_timer (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .low_freq_osc(low_freq_osc), .wdt_mode_config(wdt_mode_config), .in_sleep(in_sleep),
        .crystal_clock(crystal_clock), .watchdog_clear_instr(watchdog_clear_instr),
        .osc_fail(osc_fail), .osc_startup_timer(osc_startup_timer), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .wdt_reset_req(wdt_reset_req), .wake_req(wake_req), .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n), .wdog_reset_flag_n(wdog_reset_flag_n), .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Pulses stand one cycle, so sampling at every edge catches each exactly once.
    always @(posedge ref_clk) begin
        if (wdt_reset_req === 1'b1) rst_seen <= rst_seen + 1;
        if (wake_req === 1'b1) wake_seen <= wake_seen + 1;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Reserved period codes fall back to the shortest interval.
    function automatic int limit(input logic [4:0] p);
        return (p > PS_MAX_CODE) ? 32 : (32 << p);
    endfunction

    function automatic bit act(input int m, input bit en, input bit s);
        return (m == 3) || (m == 2 && !s) || (m == 1 && en);
    endfunction

    task automatic stop_test;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= ad;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= ad;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            low_freq_osc <= 1'b1;
            @(posedge ref_clk);
            low_freq_osc <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    task automatic pulses(input int r, input int w);
        cyc(3);
        #1;
        rst_exp += r;
        wake_exp += w;
        chk(rst_seen[7:0], rst_exp[7:0], "reset pulses");
        chk(wake_seen[7:0], wake_exp[7:0], "wake pulses");
    endtask

    task automatic pulse_src(input int k);
        @(posedge ref_clk);
        case (k)
            0: watchdog_clear_instr <= 1'b1;
            1: osc_fail <= 1'b1;
            default: osc_startup_timer <= 1'b1;
        endcase
        @(posedge ref_clk);
        watchdog_clear_instr <= 1'b0;
        osc_fail <= 1'b0;
        osc_startup_timer <= 1'b0;
    endtask

    initial begin
        #(50 * 30000);
        num_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        stop_test;
    end

    initial begin
        {rst_n, low_freq_osc, in_sleep, crystal_clock, watchdog_clear_instr} = '0;
        {osc_fail, osc_startup_timer, wr_en, rd_en, wdt_mode_config} = '0;
        ce = 1'b1;
        addr = 8'h00;
        wr_data = 8'h00;
        seed = 32'h0001_442f;
        codes = '{5'h00, 5'h01, 5'h13, 5'h1f};
        cyc(8);
        rst_n <= 1'b1;
        rd(ADDR_CONTROL, rdv);
        chk(rdv, {2'b00, PS_RESET, EN_RESET}, "control reset");
        rd(ADDR_FLAGS, rdv);
        chk(rdv, 8'h07, "flags reset");
        rd(8'h10, rdv);
        chk(rdv, 8'h00, "unmapped read");
        repeat (4) begin
            seed = xs(seed);
            wr(ADDR_CONTROL, seed[7:0]);
            rd(ADDR_CONTROL, rdv);
            chk(rdv, seed[7:0] & 8'h3f, "control readback");
        end
        $display("test registers done");
        @(posedge ref_clk) wdt_mode_config <= MODE_ON;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CONTROL, {2'b00, codes[i], 1'b0});
            pulse_src(0);
            ticks(limit(codes[i]) - 1);
            pulses(0, 0);
            ticks(1);
            pulses(1, 0);
        end
        chk({7'h00, wdog_reset_flag_n}, 8'h00, "watchdog flag");
        rd(ADDR_IRQ_STATUS, rdv);
        chk(rdv, 8'h01, "irq status");
        chk({7'h00, irq}, 8'h00, "irq masked");
        wr(ADDR_IRQ_MASK, 8'h01);
        #1 chk({7'h00, irq}, 8'h01, "irq raised");
        wr(ADDR_IRQ_STATUS, 8'h01);
        #1 chk({7'h00, irq}, 8'h00, "irq cleared");
        wr(ADDR_FLAGS, 8'h04);
        #1 chk({7'h00, wdog_reset_flag_n}, 8'h01, "flag restored");
        $display("test periods done");
        for (int k = 0; k < 3; k++) begin
            ticks(20);
            pulse_src(k);
            ticks(31);
            pulses(0, 0);
            ticks(1);
            pulses(1, 0);
        end
        ticks(31);
        @(posedge ref_clk) ce <= 1'b0;
        ticks(4);
        @(posedge ref_clk) ce <= 1'b1;
        ticks(1);
        pulses(1, 0);
        $display("test clear sources done");
        for (int m = 0; m < 4; m++) begin
            for (int e = 0; e < 2; e++) begin
                for (int s = 0; s < 2; s++) begin
                    a = act(m, e[0], s[0]);
                    @(posedge ref_clk) wdt_mode_config <= m[1:0];
                    wr(ADDR_CONTROL, {7'h00, e[0]});
                    pulse_src(0);
                    @(posedge ref_clk) in_sleep <= s[0];
                    cyc(2);
                    rd(ADDR_FLAGS, rdv);
                    chk(rdv & 8'h18, {3'b000, s[0], a, 3'b000}, "active flag");
                    if (s[0]) chk({6'h00, timeout_flag_n, powerdown_flag_n}, 8'h02, "entry");
                    ticks(32);
                    pulses(a & !s[0], a & s[0]);
                    if (s[0]) chk({7'h00, timeout_flag_n}, {7'h00, !a}, "sleep timeout");
                    @(posedge ref_clk) in_sleep <= 1'b0;
                    cyc(2);
                    rd(ADDR_CONTROL, rdv);
                    chk(rdv, {7'h00, e[0]}, "enable kept");
                end
            end
        end
        $display("test modes done");
        @(posedge ref_clk) wdt_mode_config <= MODE_ON;
        wr(ADDR_CONTROL, 8'h00);
        @(posedge ref_clk) in_sleep <= 1'b1;
        cyc(2);
        @(posedge ref_clk);
        crystal_clock <= 1'b1;
        in_sleep <= 1'b0;
        ticks(40);
        pulses(0, 0);
        pulse_src(2);
        ticks(31);
        pulses(0, 0);
        ticks(1);
        pulses(1, 0);
        $display("test crystal hold done");
        wr(ADDR_CONTROL, 8'h07);
        @(posedge ref_clk) rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        rd(ADDR_CONTROL, rdv);
        chk(rdv, {2'b00, PS_RESET, EN_RESET}, "control after reset");
        $display("test second reset done");
        stop_test;
    end
endmodule
